//--- hw/xor_dir_consts.vh
// constants for the xor and direction-load execution slice
`ifndef XOR_DIR_CONSTS_VH
`define XOR_DIR_CONSTS_VH

`define INSTR_W          14
`define DATA_W           8
`define FILE_ADDR_W      7

// opcode fields
`define OPC6_MSB         13
`define OPC6_LSB         8
`define OPC_XOR_LITERAL  6'h3A
`define OPC_XOR_FILE     6'h06
`define DIR_LOAD_MSB     13
`define DIR_LOAD_LSB     3
`define OPC_DIR_LOAD     11'h00C

// operand fields
`define LIT_MSB          7
`define LIT_LSB          0
`define DEST_BIT         7
`define FILE_MSB         6
`define FILE_LSB         0
`define DIR_SEL_MSB      2
`define DIR_SEL_LSB      0

// direction register window and reset values
`define DIR_FIRST        3'h5
`define DIR_LAST         3'h7
`define DIR_COUNT        3
`define DIR_RESET        8'hFF
`define W_RESET          8'h00
`define ZERO_RESET       1'b0
`define ADDR_RESET       7'h00

// states
`define ST_IDLE          1'b0
`define ST_FETCH         1'b1

`endif

//--- hw/opcode_match.v
// instruction class decoder for the xor and direction-load slice
`timescale 1ns/1ps
`include "xor_dir_consts.vh"

module opcode_match (
  instr_word,
  is_dir_load,
  is_xor_literal,
  is_xor_file
);
  input  wire [`INSTR_W-1:0] instr_word;
  output wire                is_dir_load;
  output wire                is_xor_literal;
  output wire                is_xor_file;

  assign is_dir_load    = (instr_word[`DIR_LOAD_MSB:`DIR_LOAD_LSB] == `OPC_DIR_LOAD);
  assign is_xor_literal = (instr_word[`OPC6_MSB:`OPC6_LSB] == `OPC_XOR_LITERAL);
  assign is_xor_file    = (instr_word[`OPC6_MSB:`OPC6_LSB] == `OPC_XOR_FILE);

endmodule // opcode_match

//--- hw/xor_and_direction_load_exec.v
// execution slice for direction load, literal xor and file xor
//
// Contract
// [RULE1] direction load copies accumulator into direction register 5, 6 or 7 only.
// [RULE2] software should use ordinary register writes instead of direction load.
// [RULE3] literal xor (prefix 11 1010) xors accumulator with 8-bit literal into accumulator.
// [RULE4] file xor (prefix 00 0110) xors accumulator with file register 0..127.
// [RULE5] destination bit 0 puts result in accumulator; memory unchanged.
// [RULE6] destination bit 1 writes result to memory; accumulator unchanged.
// [RULE7] both xors update zero flag from result; direction load leaves flags.
`timescale 1ns/1ps
`include "xor_dir_consts.vh"

module xor_and_direction_load_exec #(
  parameter DATA_W      = `DATA_W,
  parameter FILE_ADDR_W = `FILE_ADDR_W,
  parameter DIR_COUNT   = `DIR_COUNT
) (
  ref_clk,
  rst_n,
  instr_valid,
  instr_word,
  instr_ready,
  acc_load,
  acc_load_data,
  file_rdata,
  file_addr,
  file_re,
  file_we,
  file_wdata,
  acc_value,
  zero_flag,
  dir_regs,
  exec_done,
  bad_operand
);
  input  wire                          ref_clk;
  input  wire                          rst_n;
  input  wire                          instr_valid;
  input  wire [`INSTR_W-1:0]           instr_word;
  output reg                           instr_ready;
  input  wire                          acc_load;
  input  wire [DATA_W-1:0]             acc_load_data;
  input  wire [DATA_W-1:0]             file_rdata;
  output reg  [FILE_ADDR_W-1:0]        file_addr;
  output reg                           file_re;
  output reg                           file_we;
  output reg  [DATA_W-1:0]             file_wdata;
  output reg  [DATA_W-1:0]             acc_value;
  output reg                           zero_flag;
  output wire [DIR_COUNT*DATA_W-1:0]   dir_regs;
  output reg                           exec_done;
  output reg                           bad_operand;

  // true when the selector names one of the writable direction registers
  function dir_sel_ok;
    input [2:0] sel;
    begin
      dir_sel_ok = (sel >= `DIR_FIRST) && (sel <= `DIR_LAST);
    end
  endfunction

  // zero test shared by both xor paths
  function is_zero;
    input [DATA_W-1:0] val;
    begin
      is_zero = (val == {DATA_W{1'b0}});
    end
  endfunction

  wire                    is_dir_load;
  wire                    is_xor_literal;
  wire                    is_xor_file;
  wire                    take;
  wire                    take_lit;
  wire                    take_file;
  wire                    take_dir;
  wire                    dir_write;
  wire [2:0]              dir_sel;
  wire [DATA_W-1:0]       lit_result;
  wire [DATA_W-1:0]       file_result;
  reg                     state_r;
  reg                     state_nxt;
  reg                     dest_r;
  reg                     dest_nxt;
  reg                     ready_nxt;
  reg  [FILE_ADDR_W-1:0]  addr_nxt;
  reg                     re_nxt;
  reg                     we_nxt;
  reg  [DATA_W-1:0]       wdata_nxt;
  reg  [DATA_W-1:0]       acc_nxt;
  reg                     zero_nxt;
  reg                     done_nxt;
  reg                     bad_nxt;
  reg  [DATA_W-1:0]       dir_r [0:DIR_COUNT-1];

  opcode_match u_decode (
    .instr_word     (instr_word),
    .is_dir_load    (is_dir_load),
    .is_xor_literal (is_xor_literal),
    .is_xor_file    (is_xor_file)
  );

  assign take        = instr_valid && instr_ready;
  assign take_lit    = take && is_xor_literal;
  assign take_file   = take && is_xor_file;
  assign take_dir    = take && is_dir_load;
  assign dir_sel     = instr_word[`DIR_SEL_MSB:`DIR_SEL_LSB];
  // the idle test repeats what ready implies; it keeps the fetch cycle write-free on its own
  assign dir_write   = take_dir && (state_r == `ST_IDLE) && dir_sel_ok(dir_sel); // [RULE1]
  assign lit_result  = acc_value ^ instr_word[`LIT_MSB:`LIT_LSB]; // [RULE3]
  assign file_result = acc_value ^ file_rdata;                   // [RULE4]

  // file xor needs one cycle for the memory read; ready drops meanwhile
  always @* begin
    state_nxt = state_r;
    dest_nxt  = dest_r;
    ready_nxt = instr_ready;
    addr_nxt  = file_addr;
    re_nxt    = 1'b0;
    we_nxt    = 1'b0;
    wdata_nxt = file_wdata;
    acc_nxt   = acc_value;
    zero_nxt  = zero_flag;
    done_nxt  = 1'b0;
    bad_nxt   = 1'b0;
    case (state_r)
      `ST_IDLE: begin
        ready_nxt = 1'b1;
        if (take_lit) begin
          acc_nxt  = lit_result;                                 // [RULE3]
          zero_nxt = is_zero(lit_result);                        // [RULE7]
          done_nxt = 1'b1;
        end else if (take_file) begin
          addr_nxt  = instr_word[`FILE_MSB:`FILE_LSB];           // [RULE4]
          dest_nxt  = instr_word[`DEST_BIT];
          re_nxt    = 1'b1;
          ready_nxt = 1'b0;
          state_nxt = `ST_FETCH;
        end else if (take_dir) begin
          // flags deliberately untouched here
          done_nxt = 1'b1;                                       // [RULE7]
          bad_nxt  = !dir_sel_ok(dir_sel);                       // [RULE1]
        end else if (acc_load) begin
          // side load from other core paths; it loses to our own instructions and is
          // ignored in the fetch cycle, so a pending file xor result always lands
          acc_nxt = acc_load_data;
        end
      end
      `ST_FETCH: begin
        zero_nxt = is_zero(file_result);                         // [RULE7]
        if (dest_r) begin
          wdata_nxt = file_result;                               // [RULE6]
          we_nxt    = 1'b1;
        end else begin
          acc_nxt   = file_result;                               // [RULE5]
        end
        done_nxt  = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = `ST_IDLE;
      end
      default: begin
        state_nxt = `ST_IDLE;
        ready_nxt = 1'b0;
      end
    endcase
  end

  // control registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= `ST_IDLE;
      instr_ready <= 1'b0;
      dest_r      <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      instr_ready <= ready_nxt;
      dest_r      <= dest_nxt;
    end
  end

  // data path and strobe registers
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      file_addr   <= `ADDR_RESET;
      file_re     <= 1'b0;
      file_we     <= 1'b0;
      file_wdata  <= `W_RESET;
      acc_value   <= `W_RESET;
      zero_flag   <= `ZERO_RESET;
      exec_done   <= 1'b0;
      bad_operand <= 1'b0;
    end else begin
      file_addr   <= addr_nxt;
      file_re     <= re_nxt;
      file_we     <= we_nxt;
      file_wdata  <= wdata_nxt;
      acc_value   <= acc_nxt;
      zero_flag   <= zero_nxt;
      exec_done   <= done_nxt;
      bad_operand <= bad_nxt;
    end
  end

  // one direction register per selector value 5..7; out-of-window selectors write nothing
  genvar gi;
  generate
    for (gi = 0; gi < DIR_COUNT; gi = gi + 1) begin : g_dir
      // selector value that addresses this register
      localparam [31:0] SEL_CODE = `DIR_FIRST + gi;
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          dir_r[gi] <= `DIR_RESET;
        end else if (dir_write && (dir_sel == SEL_CODE[2:0])) begin
          dir_r[gi] <= acc_value;                                // [RULE1]
        end
      end
      assign dir_regs[gi*DATA_W +: DATA_W] = dir_r[gi];
    end
  endgenerate

  // ordinary writes to the direction registers arrive elsewhere in the core;
  // this slice only serves the legacy load path [RULE2]

endmodule // xor_and_direction_load_exec

//--- verification/xor_dir_props.sv
// assertions for the xor and direction-load execution slice
`timescale 1ns/1ps
module xor_dir_props (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic        file_re,
  input wire logic        file_we,
  input wire logic        zero_flag,
  input wire logic        exec_done,
  input wire logic        bad_operand,
  input wire logic [13:0] instr_word,
  input wire logic [7:0]  file_rdata,
  input wire logic [7:0]  file_wdata,
  input wire logic [7:0]  acc_value,
  input wire logic [6:0]  file_addr,
  input wire logic [23:0] dir_regs
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire tk  = instr_valid && instr_ready;
  wire lit = tk && instr_word[13:8] == 6'h3A;
  wire fx  = tk && instr_word[13:8] == 6'h06;
  wire dl  = tk && instr_word[13:3] == 11'h00C;
  chk_lit_xor: assert property (lit |=> exec_done
    && acc_value == $past(acc_value ^ instr_word[7:0]) && zero_flag == !acc_value)
    else $error("literal xor wrong");
  chk_file_read: assert property (fx |=> file_re && !instr_ready
    && file_addr == $past(instr_word[6:0])) else $error("file read wrong");
  chk_file_acc: assert property (fx && !instr_word[7] |=> ##1 exec_done
    && !file_we && acc_value == ($past(acc_value, 2) ^ $past(file_rdata))
    && zero_flag == !acc_value) else $error("file xor to accumulator wrong");
  chk_file_mem: assert property (fx && instr_word[7] |=> ##1 exec_done
    && file_we && file_wdata == ($past(acc_value) ^ $past(file_rdata))
    && $stable(acc_value) && zero_flag == !file_wdata) else $error("file xor to memory wrong");
  chk_dir_load: assert property (dl && instr_word[2:0] >= 3'h5 |=> exec_done
    && !bad_operand && dir_regs[($past(instr_word[2:0]) - 3'h5) * 8 +: 8] == $past(acc_value)
    && $stable(zero_flag)) else $error("direction load wrong");
  chk_dir_refuse: assert property (dl && instr_word[2:0] < 3'h5 |=> bad_operand
    && $stable(dir_regs) && $stable(zero_flag)) else $error("bad selector wrote");
  cover property (lit);
  cover property (fx ##2 file_we);
  cover property (dl ##1 bad_operand);
endmodule // xor_dir_props

bind xor_and_direction_load_exec xor_dir_props xor_dir_props_i (.ref_clk(ref_clk),
  .rst_n(rst_n), .instr_valid(instr_valid), .instr_ready(instr_ready), .file_re(file_re),
  .file_we(file_we), .zero_flag(zero_flag), .exec_done(exec_done),
  .bad_operand(bad_operand), .instr_word(instr_word), .file_rdata(file_rdata),
  .file_wdata(file_wdata), .acc_value(acc_value), .file_addr(file_addr), .dir_regs(dir_regs));

//--- verification/xor_and_direction_load_exec_tb_top.sv
// random and corner test of the xor and direction-load slice
`timescale 1ns/1ps
module xor_and_direction_load_exec_tb_top;
  logic        ref_clk = 0, rst_n = 0, instr_valid = 0, acc_load = 0, d, e_z, re_seen;
  logic [13:0] instr_word = 14'h0000;
  logic [7:0]  acc_load_data = 8'h00, e_acc, k, r, mem [0:127];
  logic [6:0]  f;
  logic [2:0]  s;
  logic [23:0] e_dir;
  wire  [6:0]  file_addr;
  wire  [7:0]  file_wdata, acc_value;
  wire  [23:0] dir_regs;
  wire         instr_ready, file_re, file_we, zero_flag, exec_done, bad_operand;
  wire  [7:0]  file_rdata = mem[file_addr];
  int          bad_count = 0, comparisons = 0, cycles = 0, c;
  xor_and_direction_load_exec xor_and_direction_load_exec_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .acc_load(acc_load), .acc_load_data(acc_load_data),
    .file_rdata(file_rdata), .file_addr(file_addr), .file_re(file_re), .file_we(file_we),
    .file_wdata(file_wdata), .acc_value(acc_value), .zero_flag(zero_flag),
    .dir_regs(dir_regs), .exec_done(exec_done), .bad_operand(bad_operand));
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cycles == 20000) begin
    bad_count++;
    end_of_test;
  end
  task automatic chk(string n, logic [47:0] e, logic [47:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // expected xor result with its zero flag in the lowest bit
  function automatic logic [8:0] xor_expect(logic [7:0] a, logic [7:0] b);
    return {a ^ b, (a ^ b) == 8'h00};
  endfunction
  // called at a falling edge; returns at the falling edge where done shows, or when its edge count runs out if done never shows
  task automatic op(logic [13:0] w);
    int n = 0;
    while (instr_ready !== 1'b1 && n++ < 4) @(negedge ref_clk);
    instr_valid = 1;
    instr_word = w;
    @(negedge ref_clk);
    instr_valid = 0;
    re_seen = file_re;
    while (exec_done !== 1'b1 && n++ < 8) @(negedge ref_clk);
  endtask
  initial begin
    void'($urandom(94337));
    for (int i = 0; i < 128; i++) mem[i] = $urandom;
    repeat (12) @(negedge ref_clk);
    chk("dir reset", 24'hFFFFFF, dir_regs);
    chk("reset outputs", 0, {acc_value, zero_flag, instr_ready, exec_done, file_re, file_we});
    rst_n = 1;
    e_acc = 0;
    e_z = 0;
    e_dir = 24'hFFFFFF;
    @(negedge ref_clk);
    for (int i = 0; i < 400; i++) begin
      {k, f, d} = $urandom;
      s = i < 8 ? i : $urandom;
      c = i < 8 ? 2 : $urandom % 4;
      // an echo of the accumulator, or a load of the addressed file, forces zero results
      if (i % 5 == 0) k = c == 1 ? mem[f] : e_acc;
      if (i % 16 == 3 || (i % 5 == 0 && c == 1)) begin
        acc_load = 1;
        acc_load_data = k;
        @(negedge ref_clk);
        acc_load = 0;
        e_acc = k;
      end
      case (c)
        0: begin
          op({6'h3A, k});
          {e_acc, e_z} = xor_expect(e_acc, k);
          chk("lit acc", {e_acc, e_z, 1'b1}, {acc_value, zero_flag, exec_done});
        end
        1: begin
          {r, e_z} = xor_expect(mem[f], e_acc);
          op({6'h06, d, f});
          chk("file we", {d, 1'b1, e_z}, {file_we, exec_done, zero_flag});
          chk("file addr", f, file_addr);
          if (d) mem[f] = r;
          else e_acc = r;
          if (d) chk("file wdata", r, file_wdata);
          chk("file acc", e_acc, acc_value);
        end
        2: begin
          // legacy load driven only to check it; software uses plain writes
          op({11'h00C, s});
          if (s >= 5) e_dir[(s - 5) * 8 +: 8] = e_acc;
          chk("dir load", {e_dir, s < 5}, {dir_regs, bad_operand});
          chk("dir flags", {e_acc, e_z, 1'b1}, {acc_value, zero_flag, exec_done});
        end
        default: begin
          // a word of another class is taken and ignored
          op({6'h3B, k});
          chk("foreign word", {e_acc, e_z, 1'b0}, {acc_value, zero_flag, exec_done});
        end
      endcase
      chk("read strobe", c == 1, re_seen);
    end
    end_of_test;
  end
endmodule // xor_and_direction_load_exec_tb_top
